// [rtl/video_ctrl_pkg.sv]
// Constants for the video encoder control register bank.
// Assumes a single 125 MHz core clock and a two-wire serial host port.
package video_ctrl_pkg;

  localparam int NUM_REGS = 10;
  localparam logic [7:0] LAST_INDEX = 8'h09;

  // Register indices
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h00;
  localparam logic [7:0] IDX_MODE_SELECT = 8'h01;
  localparam logic [7:0] IDX_PRIMARY_MODE = 8'h02;
  localparam logic [7:0] IDX_COEF_LSBS_FIRST = 8'h03;
  localparam logic [7:0] IDX_COEF_LSBS_PACKED = 8'h04;
  localparam logic [7:0] IDX_COEF_GREEN_LUMA_MSBS = 8'h05;
  localparam logic [7:0] IDX_COEF_GREEN_U_MSBS = 8'h06;
  localparam logic [7:0] IDX_COEF_GREEN_V_MSBS = 8'h07;
  localparam logic [7:0] IDX_COEF_BLUE_U_MSBS = 8'h08;
  localparam logic [7:0] IDX_COEF_RED_V_MSBS = 8'h09;

  // Reset values, by index
  localparam logic [7:0] RESET_VALUE [NUM_REGS] = '{
    8'h12, 8'h00, 8'h20, 8'h03, 8'hf0, 8'h4e, 8'h0e, 8'h24, 8'h92, 8'h7c
  };

  // Power control fields
  localparam int PWR_SLEEP = 0;
  localparam int PWR_PLL1_OFF = 1;
  localparam int PWR_DAC3 = 2;
  localparam int PWR_DAC2 = 3;
  localparam int PWR_DAC1 = 4;
  localparam int PWR_DAC6 = 5;
  localparam int PWR_DAC5 = 6;
  localparam int PWR_DAC4 = 7;

  // Mode select fields
  localparam int MS_EDGE_LO = 1;
  localparam int MS_EDGE_HI = 2;
  localparam int MS_INPUT_LO = 4;
  localparam int MS_INPUT_HI = 6;
  localparam int MS_BUS_SWAP = 7;

  // Primary mode fields
  localparam int PM_EXT_INTERLACE = 1;
  localparam int PM_BLACK_BAR = 2;
  localparam int PM_MANUAL_CSC = 3;
  localparam int PM_SYNC_ON_RGB = 4;
  localparam int PM_LUMA_COLOR_DIFF = 5;
  localparam int PM_SD_SYNC_OUT = 6;
  localparam int PM_HD_SYNC_OUT = 7;

  // Coefficient remainder positions; green luma sits in the first LSB register, the rest are packed
  localparam int LSB_GREEN_LUMA = 0;
  localparam int LSB_GREEN_U = 0;
  localparam int LSB_GREEN_V = 2;
  localparam int LSB_BLUE_U = 4;
  localparam int LSB_RED_V = 6;

  // Built-in conversion matrix
  localparam logic [9:0] BUILTIN_GREEN_LUMA = 10'h13b;
  localparam logic [9:0] BUILTIN_GREEN_U = 10'h038;
  localparam logic [9:0] BUILTIN_GREEN_V = 10'h090;
  localparam logic [9:0] BUILTIN_BLUE_U = 10'h24b;
  localparam logic [9:0] BUILTIN_RED_V = 10'h1f3;

  // Serial port: seven-bit slave address with the strap as bit 0
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h6a;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic SDA_LOW = 1'h0;

endpackage

// [rtl/video_encoder_control_regs.sv]
// Control register bank of a video encoder with its two-wire serial slave port.
// Assumes scl/sda/strap are asynchronous pins; companion pattern enables come
// from registers elsewhere on the same clock.
`timescale 1ns/1ps
`default_nettype none

module video_encoder_control_regs
  import video_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial host pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic addr_strap_i,
  // Companion pattern enables
  input wire logic hd_pattern_en_i,
  input wire logic sd_pattern_en_i,
  // Power controls
  output logic [5:0] dac_power_on,
  output logic pll1_power_on,
  output logic oversampling_on,
  // Mode controls
  output logic [1:0] ddr_edge_align,
  output logic [2:0] input_mode,
  output logic bus_swap,
  output logic ext_interlace_sync,
  output logic black_bar_hd,
  output logic black_bar_sd,
  output logic sync_on_rgb,
  output logic luma_color_difference,
  output logic sd_sync_out_en,
  output logic hd_sync_out_en,
  // Active colour space conversion coefficients
  output logic [9:0] coef_green_luma,
  output logic [9:0] coef_green_u,
  output logic [9:0] coef_green_v,
  output logic [9:0] coef_blue_u,
  output logic [9:0] coef_red_v
);
  import video_ctrl_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV_ADDR, ST_ADDR_ACK, ST_POINTER, ST_POINTER_ACK,
    ST_WR_DATA, ST_WR_ACK, ST_RD_DATA, ST_RD_ACK
  } port_state_e;

  logic [2:0] scl_sync_q, sda_sync_q, strap_sync_q;
  logic scl_q, sda_q, strap_q;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  port_state_e state_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q, tx_q, pointer_bits_q;
  logic byte_done_q, ack_ok_q, read_q, host_ack_q;
  logic [7:0] rx_byte;
  logic pointer_valid, wr_strobe, drive_low, ack_phase;
  logic [7:0] regs_q [NUM_REGS];

  // Filtered pin levels: a change counts once the second and third stages agree
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      strap_sync_q <= 3'h0;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      strap_sync_q <= {strap_sync_q[1:0], addr_strap_i};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      strap_q <= 1'h0;
    end else begin
      if (scl_sync_q[1] == scl_sync_q[2]) scl_q <= scl_sync_q[2];
      if (sda_sync_q[1] == sda_sync_q[2]) sda_q <= sda_sync_q[2];
      if (strap_sync_q[1] == strap_sync_q[2]) strap_q <= strap_sync_q[2];
    end
  end

  logic scl_next, sda_next;
  always_comb begin
    scl_next = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_q;
    sda_next = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_q;
    scl_rise = scl_next & ~scl_q;
    scl_fall = ~scl_next & scl_q;
    start_seen = scl_q & scl_next & sda_q & ~sda_next;
    stop_seen = scl_q & scl_next & ~sda_q & sda_next;
    rx_byte = {shift_q[6:0], sda_next};
    pointer_valid = (pointer_bits_q <= LAST_INDEX);
    ack_phase = (state_q == ST_ADDR_ACK) || (state_q == ST_POINTER_ACK)
                || (state_q == ST_WR_ACK) || (state_q == ST_RD_ACK);
    // Whole byte stored on the same clock that samples its eighth bit
    wr_strobe = scl_rise && (state_q == ST_WR_DATA) && (bit_cnt_q == LAST_BIT)
                && pointer_valid;
  end

  // Bit counter, receive shifter and per-byte acknowledge decision
  always_ff @(posedge clk) begin
    if (reset) begin
      bit_cnt_q <= FIRST_BIT;
      shift_q <= 8'h00;
      byte_done_q <= 1'h0;
      ack_ok_q <= 1'h0;
      host_ack_q <= 1'h0;
    end else if (start_seen || stop_seen) begin
      bit_cnt_q <= FIRST_BIT;
      byte_done_q <= 1'h0;
    end else if (scl_rise) begin
      if (state_q == ST_RD_ACK) host_ack_q <= ~sda_next;
      // Acknowledge clocks carry no data bit, so they are not counted
      if (!ack_phase) begin
        shift_q <= rx_byte;
        if (bit_cnt_q == LAST_BIT) begin
          byte_done_q <= 1'h1;
          bit_cnt_q <= FIRST_BIT;
          case (state_q)
            ST_DEV_ADDR: ack_ok_q <= (rx_byte[7:1] == {SLAVE_ADDR_BASE[6:1], strap_q});
            ST_POINTER: ack_ok_q <= (rx_byte <= LAST_INDEX);
            ST_WR_DATA: ack_ok_q <= pointer_valid;
            default: ack_ok_q <= 1'h1;
          endcase
        end else begin
          bit_cnt_q <= bit_cnt_q + 3'h1;
        end
      end
    end else if (scl_fall && byte_done_q) begin
      byte_done_q <= 1'h0;
    end
  end

  // Serial port sequencing
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      read_q <= 1'h0;
    end else if (stop_seen) begin
      state_q <= ST_IDLE;
    end else if (start_seen) begin
      state_q <= ST_DEV_ADDR;
    end else if (scl_fall) begin
      case (state_q)
        ST_DEV_ADDR: if (byte_done_q) begin
          state_q <= ack_ok_q ? ST_ADDR_ACK : ST_IDLE;
          read_q <= shift_q[0];
        end
        ST_ADDR_ACK: state_q <= read_q ? ST_RD_DATA : ST_POINTER;
        ST_POINTER: if (byte_done_q) state_q <= ack_ok_q ? ST_POINTER_ACK : ST_IDLE;
        ST_POINTER_ACK: state_q <= ST_WR_DATA;
        ST_WR_DATA: if (byte_done_q) state_q <= ack_ok_q ? ST_WR_ACK : ST_IDLE;
        ST_WR_ACK: state_q <= ST_WR_DATA;
        ST_RD_DATA: if (byte_done_q) state_q <= ST_RD_ACK;
        ST_RD_ACK: state_q <= host_ack_q ? ST_RD_DATA : ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Pointer: loaded from the second byte, advanced by each stored write byte and by each read byte below the last index
  always_ff @(posedge clk) begin
    if (reset) begin
      pointer_bits_q <= IDX_POWER_CONTROL;
    end else if (scl_fall && byte_done_q && state_q == ST_POINTER && ack_ok_q) begin
      pointer_bits_q <= shift_q;
    end else if (wr_strobe) begin
      pointer_bits_q <= pointer_bits_q + 8'h01;
    end else if (scl_fall && byte_done_q && state_q == ST_RD_DATA
                 && pointer_bits_q < LAST_INDEX) begin
      // Reads past the top keep returning the last register
      pointer_bits_q <= pointer_bits_q + 8'h01;
    end
  end

  // Transmit shifter: loaded as each read byte starts
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_q <= 8'hff;
    end else if (scl_fall) begin
      if ((state_q == ST_ADDR_ACK && read_q) || (state_q == ST_RD_ACK && host_ack_q)) begin
        tx_q <= pointer_valid ? regs_q[pointer_bits_q[3:0]] : 8'hff;
      end else if (state_q == ST_RD_DATA && !byte_done_q) begin
        tx_q <= {tx_q[6:0], 1'h1};
      end
    end
  end

  always_comb begin
    drive_low = (state_q == ST_ADDR_ACK) || (state_q == ST_POINTER_ACK)
                || (state_q == ST_WR_ACK) || (state_q == ST_RD_DATA && !tx_q[7]);
  end

  always_ff @(posedge clk) begin
    if (reset) sda_oe_n <= 1'h1;
    else sda_oe_n <= ~drive_low;
  end

  assign sda_o = SDA_LOW;

  // Register storage, one word per index
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge clk) begin
        if (reset) regs_q[gi] <= RESET_VALUE[gi];
        else if (wr_strobe && pointer_bits_q[3:0] == 4'(gi)) regs_q[gi] <= rx_byte;
      end
    end
  endgenerate

  // Decoded controls, held in flip-flops
  logic [7:0] pwr, msel, pmode, lsb1, lsbp;
  always_comb begin
    pwr = regs_q[IDX_POWER_CONTROL[3:0]];
    msel = regs_q[IDX_MODE_SELECT[3:0]];
    pmode = regs_q[IDX_PRIMARY_MODE[3:0]];
    lsb1 = regs_q[IDX_COEF_LSBS_FIRST[3:0]];
    lsbp = regs_q[IDX_COEF_LSBS_PACKED[3:0]];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dac_power_on <= 6'h00;
      pll1_power_on <= 1'h0;
      oversampling_on <= 1'h0;
    end else begin
      // DAC order 1..6 on bits 0..5 all gated by sleep
      dac_power_on <= {pwr[PWR_DAC6], pwr[PWR_DAC5], pwr[PWR_DAC4],
                       pwr[PWR_DAC3], pwr[PWR_DAC2], pwr[PWR_DAC1]}
                      & {6{~pwr[PWR_SLEEP]}};
      pll1_power_on <= ~pwr[PWR_SLEEP] & ~pwr[PWR_PLL1_OFF];
      oversampling_on <= ~pwr[PWR_SLEEP] & ~pwr[PWR_PLL1_OFF];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ddr_edge_align <= 2'h0;
      input_mode <= 3'h0;
      bus_swap <= 1'h0;
      ext_interlace_sync <= 1'h0;
      black_bar_hd <= 1'h0;
      black_bar_sd <= 1'h0;
      sync_on_rgb <= 1'h0;
      luma_color_difference <= 1'h0;
      sd_sync_out_en <= 1'h0;
      hd_sync_out_en <= 1'h0;
    end else begin
      ddr_edge_align <= msel[MS_EDGE_HI:MS_EDGE_LO];
      input_mode <= msel[MS_INPUT_HI:MS_INPUT_LO];
      bus_swap <= msel[MS_BUS_SWAP];
      ext_interlace_sync <= pmode[PM_EXT_INTERLACE];
      black_bar_hd <= pmode[PM_BLACK_BAR] & hd_pattern_en_i;
      black_bar_sd <= pmode[PM_BLACK_BAR] & sd_pattern_en_i;
      sync_on_rgb <= pmode[PM_SYNC_ON_RGB];
      luma_color_difference <= pmode[PM_LUMA_COLOR_DIFF];
      sd_sync_out_en <= pmode[PM_SD_SYNC_OUT];
      hd_sync_out_en <= pmode[PM_HD_SYNC_OUT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      coef_green_luma <= BUILTIN_GREEN_LUMA;
      coef_green_u <= BUILTIN_GREEN_U;
      coef_green_v <= BUILTIN_GREEN_V;
      coef_blue_u <= BUILTIN_BLUE_U;
      coef_red_v <= BUILTIN_RED_V;
    end else if (pmode[PM_MANUAL_CSC]) begin
      coef_green_luma <= {regs_q[IDX_COEF_GREEN_LUMA_MSBS[3:0]],
                          lsb1[LSB_GREEN_LUMA +: 2]};
      coef_green_u <= {regs_q[IDX_COEF_GREEN_U_MSBS[3:0]], lsbp[LSB_GREEN_U +: 2]};
      coef_green_v <= {regs_q[IDX_COEF_GREEN_V_MSBS[3:0]], lsbp[LSB_GREEN_V +: 2]};
      coef_blue_u <= {regs_q[IDX_COEF_BLUE_U_MSBS[3:0]], lsbp[LSB_BLUE_U +: 2]};
      coef_red_v <= {regs_q[IDX_COEF_RED_V_MSBS[3:0]], lsbp[LSB_RED_V +: 2]};
    end else begin
      coef_green_luma <= BUILTIN_GREEN_LUMA;
      coef_green_u <= BUILTIN_GREEN_U;
      coef_green_v <= BUILTIN_GREEN_V;
      coef_blue_u <= BUILTIN_BLUE_U;
      coef_red_v <= BUILTIN_RED_V;
    end
  end

endmodule

`default_nettype wire

// [tb/i2c_host_model.sv]
// Two-wire serial host: start, stop, byte transfers and register bursts.
// Assumes a pull-up resolves the data line; it only releases or pulls low.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  // Clock
  input wire logic clk,
  // Bus wires
  output logic scl,
  output logic sda_rel,
  input wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Clock low on entry and exit; the line is taken at the end of the high phase
  task automatic bit_cyc(input logic b, output logic s);
    wt(4);
    sda_rel = b;
    wt(8);
    scl = 1'b1;
    wt(12);
    s = sda_line;
    scl = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
    bit_cyc(1'b1, s);
    ack = ~s;
  endtask
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
    bit_cyc(~more, s);
  endtask
  task automatic start_cond();
    wt(4);
    sda_rel = 1'b1;
    wt(8);
    scl = 1'b1;
    wt(12);
    sda_rel = 1'b0;
    wt(12);
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    wt(4);
    sda_rel = 1'b0;
    wt(8);
    scl = 1'b1;
    wt(12);
    sda_rel = 1'b1;
    wt(12);
  endtask
  // Pointer always precedes data; reads use a repeated start
  task automatic xfer(input logic [6:0] addr, input logic rd, input logic [7:0] ptr,
      input int n, input logic [7:0] wd [12], output logic [7:0] rdat [12],
      output logic [13:0] acks);
    acks = '0;
    start_cond();
    put_byte({addr, 1'b0}, acks[0]);
    put_byte(ptr, acks[1]);
    if (rd) begin
      start_cond();
      put_byte({addr, 1'b1}, acks[2]);
      for (int i = 0; i < n; i++) get_byte(i < n - 1, rdat[i]);
    end else begin
      for (int i = 0; i < n; i++) put_byte(wd[i], acks[i + 2]);
    end
    stop_cond();
  endtask
endmodule
`default_nettype wire

// [tb/video_encoder_control_regs_assertions.sv]
// Concurrent checks on the ports of the encoder control register bank.
// Assumes it is bound into the design; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module video_encoder_control_regs_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_oe_n,
  // Companion enables and decoded controls
  input wire logic hd_pattern_en_i,
  input wire logic sd_pattern_en_i,
  input wire logic black_bar_hd,
  input wire logic black_bar_sd,
  input wire logic [5:0] dac_power_on,
  input wire logic pll1_power_on,
  input wire logic oversampling_on,
  input wire logic [1:0] ddr_edge_align,
  input wire logic [2:0] input_mode,
  input wire logic bus_swap,
  input wire logic [9:0] coef_green_luma,
  input wire logic [9:0] coef_red_v
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_pll_pair: assert property (pll1_power_on == oversampling_on)
    else $error("pll and oversampling controls disagree");
  a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_i)
    else $error("data line moved while clock high");
  a_sda_hold: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*8])
    else $error("driven data bit released too early");
  a_bar_hd_gate: assert property (black_bar_hd |-> $past(hd_pattern_en_i))
    else $error("high rate bar without its enable");
  a_bar_sd_gate: assert property (black_bar_sd |-> $past(sd_pattern_en_i))
    else $error("sd bar without its enable");
  a_bar_pair: assert property (black_bar_hd && $past(sd_pattern_en_i) |-> black_bar_sd)
    else $error("bars disagree on the mode bit");
  a_power_update: assert property ($changed({dac_power_on, pll1_power_on}) |-> scl_i)
    else $error("power controls moved outside a data bit");
  a_mode_update: assert property ($changed({ddr_edge_align, input_mode, bus_swap}) |-> scl_i)
    else $error("mode controls moved outside a data bit");
  a_coef_update: assert property ($changed({coef_green_luma, coef_red_v}) |-> scl_i)
    else $error("coefficients moved outside a data bit");
endmodule
`default_nettype wire

// [tb/video_encoder_control_regs_tb.sv]
// Self-checking bench for the encoder control register bank.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module video_encoder_control_regs_tb;
  import video_ctrl_pkg::*;
  typedef struct packed {logic [7:0] idx; logic [7:0] val; logic [1:0] en;} row_s;
  // Index, value, companion enables; bit 0 of the primary mode stays zero
  // Primary rows 8'h56 and 8'h2a set the external interlace bit; mode rows avoid reserved codes
  localparam row_s ROWS [20] = '{
    '{8'h00, 8'hfc, 2'h0}, '{8'h00, 8'ha8, 2'h0}, '{8'h00, 8'hfe, 2'h0}, '{8'h00, 8'hfd, 2'h0},
    '{8'h01, 8'h06, 2'h0}, '{8'h01, 8'h10, 2'h0}, '{8'h01, 8'ha0, 2'h0}, '{8'h01, 8'h36, 2'h0},
    '{8'h01, 8'hc0, 2'h0}, '{8'h00, 8'h14, 2'h0}, '{8'h02, 8'hfc, 2'h3}, '{8'h02, 8'h56, 2'h1},
    '{8'h02, 8'h2a, 2'h3}, '{8'h03, 8'h01, 2'h0}, '{8'h04, 8'he4, 2'h0}, '{8'h05, 8'ha5, 2'h0},
    '{8'h06, 8'h3c, 2'h0}, '{8'h07, 8'hc3, 2'h0}, '{8'h08, 8'h5a, 2'h0}, '{8'h09, 8'h81, 2'h0}
  };
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic strap = 1'b0;
  logic hd_en = 1'b0;
  logic sd_en = 1'b0;
  logic [6:0] dev = 7'h6a;
  logic scl, sda_rel, sda_line, sda_o, sda_oe_n, pll1_power_on, oversampling_on, bus_swap;
  logic ext_interlace_sync, black_bar_hd, black_bar_sd, sync_on_rgb, luma_color_difference;
  logic sd_sync_out_en, hd_sync_out_en;
  logic [5:0] dac_power_on;
  logic [1:0] ddr_edge_align;
  logic [2:0] input_mode;
  logic [9:0] coef_green_luma, coef_green_u, coef_green_v, coef_blue_u, coef_red_v;
  logic [7:0] m [10];
  logic [7:0] wd [12];
  logic [7:0] rdat [12];
  logic [13:0] acks;
  int err_total = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  // Open-drain wire with a pull-up
  assign sda_line = sda_rel & (sda_oe_n | sda_o);
  i2c_host_model i2c_host_model_i (.clk, .scl, .sda_rel, .sda_line);
  video_encoder_control_regs video_encoder_control_regs_i (.clk, .reset, .scl_i(scl),
    .sda_i(sda_line), .sda_o, .sda_oe_n, .addr_strap_i(strap), .hd_pattern_en_i(hd_en),
    .sd_pattern_en_i(sd_en), .dac_power_on, .pll1_power_on, .oversampling_on, .ddr_edge_align,
    .input_mode, .bus_swap, .ext_interlace_sync, .black_bar_hd, .black_bar_sd, .sync_on_rgb,
    .luma_color_difference, .sd_sync_out_en, .hd_sync_out_en, .coef_green_luma, .coef_green_u,
    .coef_green_v, .coef_blue_u, .coef_red_v);
  task automatic cmp(input string what, input logic [49:0] e, input logic [49:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic rd, input logic [7:0] ptr, input int n);
    i2c_host_model_i.xfer(dev, rd, ptr, n, wd, rdat, acks);
  endtask
  task automatic rd_check(input logic [7:0] ptr, input int n);
    int k;
    xfer(1'b1, ptr, n);
    cmp("read ack", 3'h7, acks[2:0]);
    for (int i = 0; i < n; i++) begin
      k = (ptr + i > 9) ? 9 : ptr + i;
      cmp("read data", m[k], rdat[i]);
    end
  endtask
  task automatic check_outs();
    logic [7:0] p;
    logic [7:0] q;
    logic [7:0] s;
    logic [5:0] d;
    logic pll;
    logic [49:0] e;
    logic [49:0] g;
    p = m[0];
    s = m[1];
    q = m[2];
    pll = ~p[0] & ~p[1];
    d = p[0] ? 6'h00 : {p[5], p[6], p[7], p[2], p[3], p[4]};
    cmp("power", {d, pll, pll}, {dac_power_on, pll1_power_on, oversampling_on});
    e = {s[2:1], s[6:4], s[7]};
    cmp("mode", e, {ddr_edge_align, input_mode, bus_swap});
    cmp("bars", {q[2] & hd_en, q[2] & sd_en}, {black_bar_hd, black_bar_sd});
    e = {q[1], q[4], q[5], q[6], q[7]};
    g = {ext_interlace_sync, sync_on_rgb, luma_color_difference, sd_sync_out_en, hd_sync_out_en};
    cmp("primary", e, g);
    e = {m[5], m[3][1:0], m[6], m[4][1:0], m[7], m[4][3:2], m[8], m[4][5:4], m[9], m[4][7:6]};
    if (!q[3]) e = {10'h13b, 10'h038, 10'h090, 10'h24b, 10'h1f3};
    g = {coef_green_luma, coef_green_u, coef_green_v, coef_blue_u, coef_red_v};
    cmp("coef", e, g);
  endtask
  task automatic reset_check();
    repeat (8) @(negedge clk);
    m = '{8'h12, 8'h00, 8'h20, 8'h03, 8'hf0, 8'h4e, 8'h0e, 8'h24, 8'h92, 8'h7c};
    check_outs();
    rd_check(8'h00, 12);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    reset_check();
    foreach (ROWS[r]) begin
      hd_en = ROWS[r].en[1];
      sd_en = ROWS[r].en[0];
      wd[0] = ROWS[r].val;
      xfer(1'b0, ROWS[r].idx, 1);
      cmp("write ack", 3'h7, acks[2:0]);
      m[ROWS[r].idx] = ROWS[r].val;
      check_outs();
      rd_check(ROWS[r].idx, 1);
    end
    // Burst past the last register: two bytes land, the third is refused
    wd[0] = 8'h11;
    wd[1] = 8'h22;
    wd[2] = 8'h33;
    xfer(1'b0, 8'h08, 3);
    cmp("burst ack", 5'h0f, acks[4:0]);
    m[8] = 8'h11;
    m[9] = 8'h22;
    check_outs();
    rd_check(8'h07, 4);
    // Pointer that names no register, then a normal access
    xfer(1'b0, 8'h0a, 1);
    cmp("bad pointer ack", 3'h1, acks[2:0]);
    rd_check(8'h09, 1);
    // Other strap level: old address ignored, new one answers
    strap = 1'b1;
    repeat (8) @(negedge clk);
    xfer(1'b0, 8'h01, 1);
    cmp("strap ack", 1'h0, acks[0]);
    dev = 7'h6b;
    rd_check(8'h00, 2);
    // Second reset in mid-run
    reset = 1'b1;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    reset_check();
    print_verdict();
  end
endmodule
bind video_encoder_control_regs video_encoder_control_regs_assertions
  video_encoder_control_regs_assertions_i (.clk, .reset, .scl_i, .sda_oe_n, .hd_pattern_en_i,
  .sd_pattern_en_i, .black_bar_hd, .black_bar_sd, .dac_power_on, .pll1_power_on,
  .oversampling_on, .ddr_edge_align, .input_mode, .bus_swap, .coef_green_luma, .coef_red_v);
`default_nettype wire
